// ==== safety_regs_consts.svh ====
// timing counts, command codes, field positions and reset values of the safety register set
// assumes a 100 MHz system clock and 16-bit serial frames (command byte, then data byte)
`ifndef SAFETY_REGS_CONSTS_SVH
`define SAFETY_REGS_CONSTS_SVH

// ==========================================
// timing
`define CLK_PERIOD_NS 10
`define ERR_TICK_US 5
`define ERR_TICK_CYCLES ((`ERR_TICK_US * 1000) / `CLK_PERIOD_NS)
`define PWM_UNIT_US 15
`define PWM_UNIT_TICKS (`PWM_UNIT_US / `ERR_TICK_US)
`define MS_TICK_CYCLES_DEFAULT (1000000 / `CLK_PERIOD_NS)
`define SAFE_TIMEOUT_SEL_STEP_MS 22
`define SAFE_LOCK_DELAY_MS 680
`define WDOG_FAIL_LIMIT 3'h7
`define ERR_COUNT_MAX 4'hf

// ==========================================
// serial command codes (parity bit included)
`define CMD_RD_FUNC_CONFIG 8'h3a
`define CMD_WR_FUNC_CONFIG 8'h35
`define CMD_RD_ERROR_STATUS 8'haa
`define CMD_WR_ERROR_STATUS 8'ha9
`define CMD_RD_PULSE_HIGH 8'hd7
`define CMD_WR_PULSE_HIGH 8'hd8
`define CMD_RD_PULSE_LOW 8'h59
`define CMD_WR_PULSE_LOW 8'h7e
`define CMD_RD_POWERDOWN 8'h39
`define CMD_WR_POWERDOWN 8'h99
`define CMD_RD_CRC_REF 8'h5a
`define CMD_WR_CRC_REF 8'h63
`define CMD_RD_DIAG_CTRL 8'hdd
`define CMD_WR_DIAG_CTRL 8'hcc
`define CMD_RD_DIAG_CHAN 8'hac
`define CMD_WR_DIAG_CHAN 8'hc9
`define CMD_RD_QUESTION_CFG 8'h78
`define CMD_WR_QUESTION_CFG 8'h77

// ==========================================
// field positions
`define FC_SAFE_TIMEOUT_SEL_DIS 7
`define FC_ERR_MON_MODE 6
`define FC_WDOG_MODE 5
`define FC_IGNITION_LATCH 4
`define FC_WDOG_RST_EN 3
`define FC_RESET_CHECK_OFF 2
`define FC_SPARE 1
`define FC_SUPPLY_SEL 0
`define ES_PIN_FAIL 5
`define ES_WDOG_FAIL 4
`define DC_ENABLE 7
`define DC_SDO_CTRL 6
`define DC_LEVEL 5

// ==========================================
// reset values
`define RST_FUNC_CONFIG 8'h84
`define RST_PULSE_HIGH 8'h0b
`define RST_PULSE_LOW 8'h3d
`define RST_POWERDOWN 4'hf
`define RST_CRC_REF 8'h00
`define RST_DIAG_CTRL 8'h00
`define RST_DIAG_CHAN 8'h00
`define RST_QUESTION_CFG 8'h00

`endif

// ==== safety_regs_pkg.sv ====
// types shared by the safety register set
// assumes the state codes reported by the main device state machine
package safety_regs_pkg;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_RESET = 3'b011,
    ST_DIAGNOSTIC = 3'b111,
    ST_ACTIVE = 3'b101,
    ST_SAFE = 3'b100
  } dev_state_e;

  typedef enum logic [1:0] {
    MUX_LEVEL = 2'b00,
    MUX_DIGITAL = 2'b01,
    MUX_ANALOG = 2'b10,
    MUX_INTERCONNECT = 2'b11
  } mux_mode_e;

endpackage

// ==== spi_frame_port.sv ====
// serial host port: shifts 16-bit frames in on the link clock
// assumes chip select low for a frame, data sampled on rising edges, sdo changed on falling edges
`timescale 1ns/100ps
`default_nettype none

module spi_frame_port (
  input wire logic sclk_in,
  input wire logic ncs_in,
  input wire logic sdi_in,
  input wire logic [7:0] rsp_in,
  output logic [15:0] frame_out,
  output logic done_out,
  output logic sdo_out,
  output logic sdo_oe_n_out
);

  logic [4:0] bit_cnt_q;
  logic [15:0] shift_q;
  logic done_q;
  logic sdo_q;

  // ==========================================
  // receive; chip select ends the frame because the link clock stops between frames
  always_ff @(posedge sclk_in or posedge ncs_in) begin
    if (ncs_in) begin
      bit_cnt_q <= 5'h00;
      shift_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      shift_q <= {shift_q[14:0], sdi_in};
      if (bit_cnt_q != 5'h10) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (bit_cnt_q == 5'h0f) begin
        done_q <= 1'b1;
      end
    end
  end

  // word held stable until the next frame, read by the system clock after done is synchronised
  always_ff @(posedge sclk_in) begin
    if (!ncs_in && bit_cnt_q == 5'h0f) begin
      frame_out <= {shift_q[14:0], sdi_in};
    end
  end

  // ==========================================
  // transmit: the answer byte is quasi-static, it only changes just after a frame completes
  always_ff @(negedge sclk_in or posedge ncs_in) begin
    if (ncs_in) begin
      sdo_q <= 1'b0;
    end else if (bit_cnt_q >= 5'h08 && bit_cnt_q < 5'h10) begin
      sdo_q <= rsp_in[3'h7 - bit_cnt_q[2:0]];
    end else begin
      sdo_q <= 1'b0;
    end
  end

  assign done_out = done_q;
  assign sdo_out = sdo_q;
  assign sdo_oe_n_out = ncs_in;

endmodule

`default_nettype wire

// ==== safety_config_diag_registers.sv ====
// safety configuration, error status and diagnostic register set
// assumes the main state machine, error counter source and watchdog sit outside on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "safety_regs_consts.svh"

module safety_config_diag_registers #(
  parameter int MS_TICK_CYCLES = `MS_TICK_CYCLES_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic spi_sclk_in,
  input wire logic spi_ncs_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_n_out,
  input wire logic err_trigger_pin_in,
  input wire logic ignition_input_in,
  input wire logic can_wake_event_in,
  input wire logic supply_select_pin_in,
  input wire logic mcu_reset_pin_level_in,
  input wire logic mcu_reset_drive_in,
  input wire logic [2:0] device_state_in,
  input wire logic error_event_in,
  input wire logic [2:0] wdog_fail_counter_in,
  input wire logic no_error_in,
  input wire logic [2:0] safe_timeout_sel_in,
  input wire logic [3:0] safe_lock_threshold_in,
  input wire logic next_question_in,
  output logic safe_request_out,
  output logic safe_timeout_sel_reset_out,
  output logic wdog_reset_request_out,
  output logic standby_request_out,
  output logic power_down_out,
  output logic wdog_mode_sel_out,
  output logic error_pin_fail_out,
  output logic [3:0] question_token_out,
  output logic [7:0] config_crc_reference_out,
  output logic [7:0] diag_analog_channel_out,
  output logic diag_out,
  output logic diag_oe_n_out
);

  // ==========================================
  // serial port and frame crossing
  logic [15:0] frame_w;
  logic done_w;
  logic [7:0] rsp_q;
  logic done_s1_q, done_s2_q, done_s3_q;
  logic frame_new;
  logic [7:0] cmd, wdata;
  logic in_diag;

  spi_frame_port u_port (
    .sclk_in(spi_sclk_in),
    .ncs_in(spi_ncs_in),
    .sdi_in(spi_sdi_in),
    .rsp_in(rsp_q),
    .frame_out(frame_w),
    .done_out(done_w),
    .sdo_out(spi_sdo_out),
    .sdo_oe_n_out(spi_sdo_oe_n_out)
  );

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
    end else begin
      done_s1_q <= done_w;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
    end
  end

  // frame word is stable long before the synchronised done edge arrives
  assign frame_new = done_s2_q && !done_s3_q;
  assign cmd = frame_w[15:8];
  assign wdata = frame_w[7:0];
  assign in_diag = device_state_in == safety_regs_pkg::ST_DIAGNOSTIC;

  // ==========================================
  // pin synchronisers
  logic [1:0] err_sy_q, ign_sy_q, wake_sy_q, sup_sy_q, rpin_sy_q, ncs_sy_q, sdi_sy_q, sclk_sy_q;
  logic [1:0] rdrv_dly_q;
  logic err_prev_q, ign_prev_q, wake_prev_q;
  logic wake_edge, ign_rise;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      err_sy_q <= 2'h0;
      ign_sy_q <= 2'h0;
      wake_sy_q <= 2'h0;
      sup_sy_q <= 2'h0;
      rpin_sy_q <= 2'h0;
      ncs_sy_q <= 2'h3;
      sdi_sy_q <= 2'h0;
      sclk_sy_q <= 2'h0;
      rdrv_dly_q <= 2'h0;
      err_prev_q <= 1'b0;
      ign_prev_q <= 1'b0;
      wake_prev_q <= 1'b0;
    end else begin
      err_sy_q <= {err_sy_q[0], err_trigger_pin_in};
      ign_sy_q <= {ign_sy_q[0], ignition_input_in};
      wake_sy_q <= {wake_sy_q[0], can_wake_event_in};
      sup_sy_q <= {sup_sy_q[0], supply_select_pin_in};
      rpin_sy_q <= {rpin_sy_q[0], mcu_reset_pin_level_in};
      ncs_sy_q <= {ncs_sy_q[0], spi_ncs_in};
      sdi_sy_q <= {sdi_sy_q[0], spi_sdi_in};
      sclk_sy_q <= {sclk_sy_q[0], spi_sclk_in};
      // driver delayed to match the pin synchroniser, so the two are compared aligned
      rdrv_dly_q <= {rdrv_dly_q[0], mcu_reset_drive_in};
      err_prev_q <= err_sy_q[1];
      ign_prev_q <= ign_sy_q[1];
      wake_prev_q <= wake_sy_q[1];
    end
  end

  assign wake_edge = wake_sy_q[1] && !wake_prev_q;
  assign ign_rise = ign_sy_q[1] && !ign_prev_q;

  // ==========================================
  // function configuration
  logic safe_timeout_sel_dis_q, mon_mode_q, wdog_mode_q, ign_latch_q, wdog_rst_en_q, rst_check_off_q, spare_q;
  logic supply_sel_q, strap_done_q;
  logic [1:0] strap_wait_q;
  logic wr_func;

  assign wr_func = frame_new && cmd == `CMD_WR_FUNC_CONFIG && in_diag;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      safe_timeout_sel_dis_q <= 1'(`RST_FUNC_CONFIG >> `FC_SAFE_TIMEOUT_SEL_DIS);
      mon_mode_q <= 1'b0;
      wdog_mode_q <= 1'b0;
      wdog_rst_en_q <= 1'b0;
      rst_check_off_q <= 1'b1;
      spare_q <= 1'b0;
    end else if (wr_func) begin
      safe_timeout_sel_dis_q <= wdata[`FC_SAFE_TIMEOUT_SEL_DIS];
      mon_mode_q <= wdata[`FC_ERR_MON_MODE];
      wdog_mode_q <= wdata[`FC_WDOG_MODE];
      wdog_rst_en_q <= wdata[`FC_WDOG_RST_EN];
      rst_check_off_q <= wdata[`FC_RESET_CHECK_OFF];
      spare_q <= wdata[`FC_SPARE];
    end
  end

  // the write only happens in DIAGNOSTIC; a wake event clears it otherwise
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ign_latch_q <= 1'b0;
    end else if (wr_func) begin
      ign_latch_q <= wdata[`FC_IGNITION_LATCH];
    end else if (wake_edge) begin
      ign_latch_q <= 1'b0;
    end
  end

  // strap caught a few cycles after release, once the synchroniser holds the real pin level
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      strap_wait_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      strap_done_q <= strap_wait_q == 2'h3;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!strap_done_q && strap_wait_q == 2'h3) begin
      supply_sel_q <= sup_sy_q[1];
    end
  end

  // ==========================================
  // error signal monitor on the pin
  logic [8:0] tick_div_q;
  logic tick;
  logic [9:0] phase_q, limit;
  logic phase_checked, mon_fail;
  logic [7:0] pulse_high_q, pulse_low_q;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || tick) begin
      tick_div_q <= 9'h000;
    end else begin
      tick_div_q <= tick_div_q + 9'h001;
    end
  end

  assign tick = tick_div_q == 9'(`ERR_TICK_CYCLES - 1);

  always_comb begin
    if (!mon_mode_q) begin
      // units of 5 us; the 15 us unit is three of them
      if (err_sy_q[1]) begin
        limit = 10'((10'(pulse_high_q) + 10'h001) * `PWM_UNIT_TICKS);
      end else begin
        limit = 10'((10'(pulse_low_q) + 10'h001) * `PWM_UNIT_TICKS);
      end
      phase_checked = 1'b1;
    end else begin
      limit = 10'(pulse_low_q) + 10'h001;
      phase_checked = !err_sy_q[1];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || err_sy_q[1] != err_prev_q) begin
      phase_q <= 10'h000;
    end else if (tick && phase_q != 10'h3ff) begin
      phase_q <= phase_q + 10'h001;
    end
  end

  // fires once per phase, on the tick that takes it past the limit
  assign mon_fail = tick && phase_checked && phase_q == limit && err_sy_q[1] == err_prev_q;

  // ==========================================
  // error status, counters and requests
  logic pin_fail_q, wdog_fail_q;
  logic [3:0] err_count_q, pd_thr_q;
  logic wr_stat, wdog_at_limit;

  assign wr_stat = frame_new && cmd == `CMD_WR_ERROR_STATUS;
  assign wdog_at_limit = wdog_fail_counter_in == `WDOG_FAIL_LIMIT;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pin_fail_q <= 1'b0;
    end else if (mon_fail && !no_error_in) begin
      pin_fail_q <= 1'b1;
    end else if (wr_stat) begin
      pin_fail_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      wdog_fail_q <= 1'b0;
    end else if (wdog_at_limit && wdog_rst_en_q) begin
      wdog_fail_q <= 1'b1;
    end else if (wr_stat && !wdog_at_limit) begin
      wdog_fail_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      err_count_q <= 4'h0;
    end else if (wr_stat && in_diag) begin
      err_count_q <= wdata[3:0];
    end else if (error_event_in && err_count_q != `ERR_COUNT_MAX) begin
      err_count_q <= err_count_q + 4'h1;
    end
  end

  // set only on the step that reaches the threshold, so recovery does not relatch at once
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      power_down_out <= 1'b0;
    end else if (error_event_in && !(wr_stat && in_diag) && err_count_q != `ERR_COUNT_MAX &&
                 err_count_q + 4'h1 == pd_thr_q) begin
      power_down_out <= 1'b1;
    end else if (wake_edge || ign_rise) begin
      power_down_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      safe_request_out <= 1'b0;
      wdog_reset_request_out <= 1'b0;
      standby_request_out <= 1'b0;
    end else begin
      safe_request_out <= pin_fail_q ||
        (!rst_check_off_q && device_state_in == safety_regs_pkg::ST_ACTIVE &&
         rpin_sy_q[1] != rdrv_dly_q[1]);
      wdog_reset_request_out <= wdog_rst_en_q && wdog_at_limit;
      standby_request_out <= !ign_latch_q && !ign_sy_q[1];
    end
  end

  // ==========================================
  // SAFE state time-out
  logic [16:0] ms_div_q;
  logic [9:0] ms_cnt_q, safe_target;
  logic locked, ms_tick;

  assign locked = {1'b0, err_count_q} >= {1'b0, safe_lock_threshold_in} + 5'h01;
  assign safe_target = locked ? 10'(`SAFE_LOCK_DELAY_MS) :
    10'((10'({safe_timeout_sel_in, 1'b0}) + 10'h001) * `SAFE_TIMEOUT_SEL_STEP_MS);
  assign ms_tick = ms_div_q == 17'(MS_TICK_CYCLES - 1);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || device_state_in != safety_regs_pkg::ST_SAFE || ms_tick) begin
      ms_div_q <= 17'h00000;
    end else begin
      ms_div_q <= ms_div_q + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || device_state_in != safety_regs_pkg::ST_SAFE) begin
      ms_cnt_q <= 10'h000;
      safe_timeout_sel_reset_out <= 1'b0;
    end else begin
      safe_timeout_sel_reset_out <= 1'b0;
      if (ms_tick && ms_cnt_q < safe_target) begin
        ms_cnt_q <= ms_cnt_q + 10'h001;
        // locked with time-out disabled: never leaves SAFE
        if (ms_cnt_q + 10'h001 == safe_target && !(locked && safe_timeout_sel_dis_q)) begin
          safe_timeout_sel_reset_out <= 1'b1;
        end
      end
    end
  end

  // ==========================================
  // DIAGNOSTIC-only settings and diagnostic registers
  logic [7:0] diag_ctrl_q, diag_chan_q;
  logic [3:0] question_feedback_q, seed_q;
  logic [7:0] dig_vec;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pulse_high_q <= `RST_PULSE_HIGH;
      pulse_low_q <= `RST_PULSE_LOW;
      pd_thr_q <= `RST_POWERDOWN;
      config_crc_reference_out <= `RST_CRC_REF;
      question_feedback_q <= 4'(`RST_QUESTION_CFG >> 4);
      seed_q <= 4'(`RST_QUESTION_CFG);
    end else if (frame_new && in_diag) begin
      case (cmd)
        `CMD_WR_PULSE_HIGH: pulse_high_q <= wdata;
        `CMD_WR_PULSE_LOW: pulse_low_q <= wdata;
        `CMD_WR_POWERDOWN: pd_thr_q <= wdata[3:0];
        `CMD_WR_CRC_REF: config_crc_reference_out <= wdata;
        `CMD_WR_QUESTION_CFG: begin
          question_feedback_q <= wdata[7:4];
          seed_q <= wdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      diag_ctrl_q <= `RST_DIAG_CTRL;
      diag_chan_q <= `RST_DIAG_CHAN;
    end else if (frame_new && cmd == `CMD_WR_DIAG_CTRL) begin
      diag_ctrl_q <= wdata;
    end else if (frame_new && cmd == `CMD_WR_DIAG_CHAN) begin
      diag_chan_q <= wdata;
    end
  end

  // question generator: seed write restarts the sequence, feedback taps pick the order
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      question_token_out <= 4'h0;
    end else if (frame_new && in_diag && cmd == `CMD_WR_QUESTION_CFG) begin
      question_token_out <= wdata[3:0];
    end else if (next_question_in && wdog_mode_q) begin
      question_token_out <= {question_token_out[2:0],
        question_token_out[3] ^ (^(question_token_out & question_feedback_q))};
    end
  end

  assign dig_vec = {power_down_out, pin_fail_q, wdog_fail_q, safe_request_out,
                    standby_request_out, ign_sy_q[1], err_sy_q[1], supply_sel_q};

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      diag_out <= 1'b0;
      diag_analog_channel_out <= 8'h00;
    end else begin
      diag_analog_channel_out <= 8'h00;
      case (diag_ctrl_q[1:0])
        safety_regs_pkg::MUX_LEVEL: diag_out <= diag_ctrl_q[`DC_LEVEL];
        safety_regs_pkg::MUX_DIGITAL: diag_out <= dig_vec[diag_chan_q[2:0]];
        safety_regs_pkg::MUX_ANALOG: begin
          // analog path lives outside; only the channel number is handed on
          diag_out <= 1'b0;
          diag_analog_channel_out <= diag_chan_q;
        end
        safety_regs_pkg::MUX_INTERCONNECT: begin
          case (diag_ctrl_q[4:2])
            3'h1: diag_out <= err_sy_q[1];
            3'h2: diag_out <= ncs_sy_q[1];
            3'h3: diag_out <= sdi_sy_q[1];
            3'h4: diag_out <= sclk_sy_q[1];
            default: diag_out <= 1'b0;
          endcase
        end
        default: diag_out <= 1'b0;
      endcase
    end
  end

  assign diag_oe_n_out = !diag_ctrl_q[`DC_ENABLE];

  // ==========================================
  // read answers, returned in the data byte of the following frame
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      rsp_q <= 8'h00;
    end else if (frame_new) begin
      case (cmd)
        `CMD_RD_FUNC_CONFIG: rsp_q <= {safe_timeout_sel_dis_q, mon_mode_q, wdog_mode_q, ign_latch_q,
                                       wdog_rst_en_q, rst_check_off_q, spare_q, supply_sel_q};
        `CMD_RD_ERROR_STATUS: rsp_q <= {2'h0, pin_fail_q, wdog_fail_q, err_count_q};
        `CMD_RD_PULSE_HIGH: rsp_q <= pulse_high_q;
        `CMD_RD_PULSE_LOW: rsp_q <= pulse_low_q;
        `CMD_RD_POWERDOWN: rsp_q <= {4'h0, pd_thr_q};
        `CMD_RD_CRC_REF: rsp_q <= config_crc_reference_out;
        `CMD_RD_DIAG_CTRL: rsp_q <= diag_ctrl_q;
        `CMD_RD_DIAG_CHAN: rsp_q <= diag_chan_q;
        `CMD_RD_QUESTION_CFG: rsp_q <= {question_feedback_q, seed_q};
        default: rsp_q <= 8'h00;
      endcase
    end
  end

  assign wdog_mode_sel_out = wdog_mode_q;
  assign error_pin_fail_out = pin_fail_q;

endmodule

`default_nettype wire

// ==== spi_host_model.sv ====
// host model: drives 16-bit frames on its own 30 ns link clock
// assumes tx is stable at the start pulse; rx keeps the data byte seen on sdo
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic start_in,
  input wire logic [15:0] tx_in,
  input wire logic sdo_in,
  output logic sclk_out,
  output logic ncs_out,
  output logic sdi_out,
  output logic busy_out,
  output logic [7:0] rx_out
);
  // ==========
  // frame
  initial begin
    {sclk_out, ncs_out, sdi_out, busy_out, rx_out} = 12'h600;
  end
  // clock stands still between frames; a released sdi shows the inverse, not a stale bit
  always @(posedge start_in) begin
    busy_out = 1'b1;
    #7 ncs_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_out = tx_in[i];
      #15 sclk_out = 1'b1;
      if (i < 8) rx_out[i] = sdo_in;
      #15 sclk_out = 1'b0;
    end
    #15 ncs_out = 1'b1;
    sdi_out = ~sdi_out;
    #60 busy_out = 1'b0;
  end
endmodule
`default_nettype wire

// ==== safety_regs_properties.sv ====
// checker for the safety register set, bound to its top module
// assumes all watched relations live in the ref_clk_in domain
`timescale 1ns/100ps
`default_nettype none
module safety_regs_checker #(parameter int MS_TICK_CYCLES = 100000) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic can_wake_event_in,
  input wire logic ignition_input_in,
  input wire logic err_trigger_pin_in,
  input wire logic error_event_in,
  input wire logic [2:0] device_state_in,
  input wire logic [2:0] wdog_fail_counter_in,
  input wire logic safe_timeout_sel_reset_out,
  input wire logic safe_request_out,
  input wire logic wdog_reset_request_out,
  input wire logic standby_request_out,
  input wire logic power_down_out,
  input wire logic error_pin_fail_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ==========
  // helpers
  logic pin_q;
  logic [10:0] phase_q;
  int safe_cnt_q;
  // raw pin phase runs ahead of the synced one, so its bound is a safe lower limit
  always_ff @(posedge ref_clk_in) begin
    pin_q <= err_trigger_pin_in;
    if (reset_in || pin_q != err_trigger_pin_in) phase_q <= 11'h000;
    else if (!phase_q[10]) phase_q <= phase_q + 11'h001;
  end
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || device_state_in != 3'h4) safe_cnt_q <= 0;
    else safe_cnt_q <= safe_cnt_q + 1;
  end
  sequence quiet_wake_s;
    (!can_wake_event_in && !ignition_input_in) [*6];
  endsequence
  // ==========
  // properties
  wd_req_a: assert property ((wdog_fail_counter_in != 3'h7) [*2] |-> !wdog_reset_request_out)
    else $error("reset request without fail count of 7");
  pulse_once_a: assert property (safe_timeout_sel_reset_out |=> !safe_timeout_sel_reset_out)
    else $error("safe time-out pulse too long");
  safe_delay_a: assert property (safe_timeout_sel_reset_out |-> safe_cnt_q >= 22 * MS_TICK_CYCLES - 3)
    else $error("safe time-out too early");
  pd_cause_a: assert property ($rose(power_down_out) |-> $past(error_event_in) || $past(error_event_in, 2))
    else $error("power down without error event");
  pd_hold_a: assert property (quiet_wake_s ##0 power_down_out |=> power_down_out)
    else $error("power down left without wake");
  standby_block_a: assert property (ignition_input_in [*5] |-> !standby_request_out)
    else $error("standby request with ignition high");
  pin_phase_a: assert property ($rose(error_pin_fail_out) |-> phase_q >= 11'h1ea)
    else $error("pin failure before one tick");
  pin_safe_a: assert property (error_pin_fail_out [*2] |-> safe_request_out)
    else $error("pin failure without safe request");
endmodule
bind safety_config_diag_registers safety_regs_checker #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) safety_regs_checker_i (.*);
`default_nettype wire

// ==== safety_config_diag_registers_tb.sv ====
// bench for the safety register set: host frames plus state codes and pin levels
// assumes the host model owns the link clock; inputs change on falling ref edges
`timescale 1ns/100ps
`default_nettype none
`include "safety_regs_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected %0t got %h want %h", $time, a, b); end end
module safety_config_diag_registers_tb;
  logic ref_clk_in, reset_in, spi_sclk_in, spi_ncs_in, spi_sdi_in, spi_sdo_out, spi_sdo_oe_n_out, go, busy;
  logic err_trigger_pin_in, ignition_input_in, can_wake_event_in, supply_select_pin_in, next_question_in;
  logic mcu_reset_pin_level_in, mcu_reset_drive_in, error_event_in, no_error_in, diag_out, diag_oe_n_out;
  logic safe_request_out, safe_timeout_sel_reset_out, wdog_reset_request_out, standby_request_out, power_down_out;
  logic wdog_mode_sel_out, error_pin_fail_out;
  logic [2:0] device_state_in, wdog_fail_counter_in, safe_timeout_sel_in;
  logic [3:0] safe_lock_threshold_in, question_token_out;
  logic [7:0] config_crc_reference_out, diag_analog_channel_out, rx;
  logic [15:0] tx;
  int n_mismatch, num_checks, n;
  // short ms tick keeps the 680 ms wait near 6800 cycles
  safety_config_diag_registers #(.MS_TICK_CYCLES(10)) safety_config_diag_registers_i (.*);
  spi_host_model spi_host_model_i (.start_in(go), .tx_in(tx), .sdo_in(spi_sdo_out), .sclk_out(spi_sclk_in),
    .ncs_out(spi_ncs_in), .sdi_out(spi_sdi_in), .busy_out(busy), .rx_out(rx));
  // ==========
  // tasks
  task automatic xfer(input logic [7:0] c, input logic [7:0] d);
    @(negedge ref_clk_in) tx = {c, d};
    go = 1'b1;
    @(negedge ref_clk_in) go = 1'b0;
    for (int i = 0; i < 90 && busy; i++) @(negedge ref_clk_in);
    repeat (6) @(negedge ref_clk_in);
  endtask
  // answers arrive one frame late
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    xfer(c, 8'h00);
    xfer(8'h00, 8'h00);
    `CHK(rx, e)
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #400000 n_mismatch++;
    end_of_test();
  end
  initial begin
    {reset_in, go, err_trigger_pin_in, ignition_input_in, can_wake_event_in, supply_select_pin_in} = 6'h2d;
    {mcu_reset_pin_level_in, mcu_reset_drive_in, error_event_in, no_error_in, next_question_in} = 5'h00;
    {device_state_in, wdog_fail_counter_in, safe_timeout_sel_in, safe_lock_threshold_in, tx} = 29'h1c000002 << 16;
    repeat (10) @(negedge ref_clk_in);
    reset_in = 1'b0;
    repeat (8) @(negedge ref_clk_in);
    rd(`CMD_RD_FUNC_CONFIG, 8'h85);
    rd(`CMD_RD_PULSE_HIGH, 8'h0b);
    rd(`CMD_RD_PULSE_LOW, 8'h3d);
    device_state_in = 3'b101;
    xfer(`CMD_WR_CRC_REF, 8'h5a);
    xfer(`CMD_WR_POWERDOWN, 8'h03);
    rd(`CMD_RD_CRC_REF, 8'h00);
    rd(`CMD_RD_POWERDOWN, 8'h0f);
    device_state_in = 3'b111;
    xfer(`CMD_WR_CRC_REF, 8'h5a);
    xfer(`CMD_WR_POWERDOWN, 8'h03);
    xfer(`CMD_WR_FUNC_CONFIG, 8'h68);
    rd(`CMD_RD_FUNC_CONFIG, 8'h69);
    `CHK(config_crc_reference_out, 8'h5a)
    `CHK(wdog_mode_sel_out, 1'b1)
    xfer(`CMD_WR_QUESTION_CFG, 8'h31);
    `CHK(question_token_out, 4'h1)
    next_question_in = 1'b1;
    @(negedge ref_clk_in) next_question_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    `CHK(question_token_out, 4'h3)
    wdog_fail_counter_in = 3'h7;
    repeat (4) @(negedge ref_clk_in);
    `CHK(wdog_reset_request_out, 1'b1)
    xfer(`CMD_WR_ERROR_STATUS, 8'h00);
    rd(`CMD_RD_ERROR_STATUS, 8'h10);
    wdog_fail_counter_in = 3'h0;
    xfer(`CMD_WR_ERROR_STATUS, 8'h00);
    rd(`CMD_RD_ERROR_STATUS, 8'h00);
    device_state_in = 3'b101;
    mcu_reset_pin_level_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    `CHK(safe_request_out, 1'b1)
    {mcu_reset_pin_level_in, ignition_input_in} = 2'b00;
    for (int i = 0; i < 6; i++) @(negedge ref_clk_in) error_event_in = !error_event_in;
    repeat (4) @(negedge ref_clk_in);
    `CHK({power_down_out, standby_request_out}, 2'b11)
    xfer(`CMD_WR_ERROR_STATUS, 8'h0f);
    rd(`CMD_RD_ERROR_STATUS, 8'h03);
    can_wake_event_in = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    `CHK(power_down_out, 1'b0)
    device_state_in = 3'b100;
    n = 0;
    while (!safe_timeout_sel_reset_out && n < 7000) @(negedge ref_clk_in) n++;
    `CHK(n > 6790 && n < 6810, 1'b1)
    device_state_in = 3'b111;
    xfer(`CMD_WR_PULSE_LOW, 8'h01);
    xfer(`CMD_WR_ERROR_STATUS, 8'h00);
    // count now below the lock level: select 1 gives (2*1+1)*22 ms
    {device_state_in, safe_timeout_sel_in} = 6'h21;
    n = 0;
    while (!safe_timeout_sel_reset_out && n < 7000) @(negedge ref_clk_in) n++;
    `CHK(n, 660)
    device_state_in = 3'b101;
    err_trigger_pin_in = 1'b0;
    repeat (900) @(negedge ref_clk_in);
    `CHK(error_pin_fail_out, 1'b0)
    repeat (700) @(negedge ref_clk_in);
    `CHK({error_pin_fail_out, safe_request_out}, 2'b11)
    err_trigger_pin_in = 1'b1;
    xfer(`CMD_WR_ERROR_STATUS, 8'h00);
    `CHK(error_pin_fail_out, 1'b0)
    xfer(`CMD_WR_DIAG_CTRL, 8'ha0);
    `CHK({diag_oe_n_out, diag_out}, 2'b01)
    xfer(`CMD_WR_DIAG_CHAN, 8'h17);
    xfer(`CMD_WR_DIAG_CTRL, 8'h02);
    `CHK({diag_oe_n_out, diag_analog_channel_out}, 9'h117)
    xfer(`CMD_WR_DIAG_CHAN, 8'h10);
    xfer(`CMD_WR_DIAG_CTRL, 8'h01);
    `CHK({spi_sdo_oe_n_out, diag_out}, 2'b11)
    xfer(`CMD_WR_DIAG_CTRL, 8'h13);
    `CHK(diag_out, 1'b0)
    end_of_test();
  end
endmodule
`default_nettype wire
